//--- verilog/lin_control_data_buffer.sv
// Purpose: Control register, status flags and frame data bytes of a LIN controller.
// Assumes: Frame engine pulses are one core_clk cycle; engine inputs synchronous.
// Notes:   Read data stand in the cycle after the read strobe only.
// Contract
// - Master or slave bits work in own mode
// - Halt write blocks traffic until next break
// - Sleep bit enters sleep on frame/timeout
// - Sleep bit clear wakes on wakeup
// - Direction bit selects transmit or receive
// - Interrupt clear strobe clears pending flag
// - Error clear strobe clears error flags
// - Wake request drives wakeup, self-clears
// - Start request begins master frame
// - Start request clears on done or error
// - Control zero at reset; three strobes
// - Done set on completion, cleared at start
// - Pending flag held until clear strobe
`timescale 1ns/1ps
`default_nettype none
module lin_control_data_buffer
	import link_ctrl_pkg::*;
(
	input  wire logic                        core_clk,
	input  wire logic                        rst,
	input  wire logic [ADDR_W-1:0]           reg_addr,
	input  wire logic [DATA_W-1:0]           reg_wdata,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	output logic      [DATA_W-1:0]           reg_rdata,
	input  wire logic                        master_mode,
	input  wire logic                        bus_active,
	input  wire logic                        frame_done,
	input  wire logic                        frame_error,
	input  wire logic                        frame_aborted,
	input  wire logic                        break_detected,
	input  wire logic                        sleep_frame_rx,
	input  wire logic                        idle_timeout,
	input  wire logic                        wakeup_rx,
	input  wire logic                        wakeup_sent,
	input  wire logic                        data_id_rx,
	input  wire logic                        rx_byte_we,
	input  wire logic [BIDX_W-1:0]           rx_byte_idx,
	input  wire logic [DATA_W-1:0]           rx_byte,
	output logic      [NUM_BYTES*DATA_W-1:0] frame_bytes,
	output logic                             frame_start,
	output logic                             frame_direction,
	output logic                             slave_data_ack,
	output logic                             comm_halted,
	output logic                             sleep_mode,
	output logic                             wake_request,
	output logic                             err_clear_strobe,
	output logic                             irq
);
	logic [DATA_W-1:0] frame_byte [NUM_BYTES];
	logic              sleep_enable;
	logic              frame_start_request;
	logic              done_flag;
	logic              irq_pending_flag;
	logic              error_flag;
	logic              bus_idle_timeout_flag;
	logic              abort_flag;
	logic              slave_data_request;
	logic              wakeup_seen;
	logic [IRQ_W-1:0]  irq_status;
	logic [IRQ_W-1:0]  irq_mask;
	logic [IRQ_W-1:0]  irq_events;
	logic              slave_mode;
	logic              ctl_wr;
	logic              byte_sel;
	logic [BIDX_W-1:0] byte_idx;
	logic              irq_clear_strobe;
	logic              halt_wr;
	logic [DATA_W-1:0] next_rdata;
	logic [DATA_W-1:0] ctrl_view;
	logic [DATA_W-1:0] status_view;

	assign slave_mode = !master_mode;
	assign ctl_wr = reg_wr && (reg_addr == LINK_CONTROL_OFF);
	assign byte_sel = (reg_addr >= FRAME_DATA_BYTE_3_OFF) && (reg_addr <= FRAME_DATA_BYTE_6_OFF);
	assign byte_idx = BIDX_W'(reg_addr - FRAME_DATA_BYTE_3_OFF);
	// Strobes act in the write cycle only and are never stored
	assign irq_clear_strobe = ctl_wr && reg_wdata[CTL_ICLR];
	assign err_clear_strobe = ctl_wr && reg_wdata[CTL_ECLR];
	assign halt_wr = ctl_wr && reg_wdata[CTL_HALT] && slave_mode;
	// Start pulses only from a master-mode write; software orders loads first
	assign frame_start = ctl_wr && reg_wdata[CTL_START] && master_mode;

	// Software write wins over engine fill in the same cycle
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NUM_BYTES; i++) begin
				frame_byte[i] <= BYTE_RESET;
			end
		end else if (reg_wr && byte_sel) begin
			frame_byte[byte_idx] <= reg_wdata;
		end else if (rx_byte_we) begin
			frame_byte[rx_byte_idx] <= rx_byte;
		end
	end

	always_comb begin
		for (int i = 0; i < NUM_BYTES; i++) begin
			frame_bytes[i*DATA_W +: DATA_W] = frame_byte[i];
		end
	end

	// Read-write control bits
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sleep_enable <= CTRL_RESET[CTL_SLEEP];
			frame_direction <= CTRL_RESET[CTL_DIR];
		end else if (ctl_wr) begin
			frame_direction <= reg_wdata[CTL_DIR];
			if (slave_mode) begin
				sleep_enable <= reg_wdata[CTL_SLEEP];
			end
		end
	end

	// New start request wins over completion of the previous frame
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			frame_start_request <= CTRL_RESET[CTL_START];
		end else if (frame_start) begin
			frame_start_request <= 1'b1;
		end else if (frame_done || frame_error) begin
			frame_start_request <= 1'b0;
		end
	end

	// Ack is held one cycle, then dropped by hardware
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			slave_data_ack <= CTRL_RESET[CTL_DACK];
		end else begin
			slave_data_ack <= ctl_wr && reg_wdata[CTL_DACK] && slave_mode;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wake_request <= CTRL_RESET[CTL_WAKE];
		end else if (ctl_wr && reg_wdata[CTL_WAKE]) begin
			wake_request <= 1'b1;
		end else if (wakeup_sent) begin
			wake_request <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			comm_halted <= 1'b0;
		end else if (halt_wr) begin
			comm_halted <= 1'b1;
		end else if (break_detected) begin
			comm_halted <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sleep_mode <= 1'b0;
		end else if (slave_mode && sleep_enable && (sleep_frame_rx || idle_timeout)) begin
			sleep_mode <= 1'b1;
		end else if ((!sleep_enable && wakeup_rx) || wake_request) begin
			sleep_mode <= 1'b0;
		end
	end

	// Status flags: hardware set wins over any clear in the same cycle
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			done_flag <= 1'b0;
		end else if (frame_done) begin
			done_flag <= 1'b1;
		end else if (frame_start) begin
			done_flag <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irq_pending_flag <= 1'b0;
		end else if (|irq_events) begin
			irq_pending_flag <= 1'b1;
		end else if (irq_clear_strobe) begin
			irq_pending_flag <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			error_flag <= 1'b0;
		end else if (frame_error) begin
			error_flag <= 1'b1;
		end else if (err_clear_strobe) begin
			error_flag <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			bus_idle_timeout_flag <= 1'b0;
			abort_flag <= 1'b0;
			slave_data_request <= 1'b0;
			wakeup_seen <= 1'b0;
		end else begin
			if (idle_timeout && slave_mode) begin
				bus_idle_timeout_flag <= 1'b1;
			end else if (break_detected || sleep_mode) begin
				bus_idle_timeout_flag <= 1'b0;
			end
			if (halt_wr || (frame_aborted && slave_mode)) begin
				abort_flag <= 1'b1;
			end else if (break_detected) begin
				abort_flag <= 1'b0;
			end
			if (data_id_rx && slave_mode) begin
				slave_data_request <= 1'b1;
			end else if (slave_data_ack) begin
				slave_data_request <= 1'b0;
			end
			if (wakeup_rx) begin
				wakeup_seen <= 1'b1;
			end else if (irq_clear_strobe) begin
				wakeup_seen <= 1'b0;
			end
		end
	end

	assign irq_events = {frame_aborted && slave_mode, idle_timeout && slave_mode, wakeup_rx,
		data_id_rx && slave_mode, frame_error, frame_done};

	// Sticky interrupt causes, write one to clear, event wins
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irq_status <= IRQ_RESET;
			irq_mask <= IRQ_RESET;
		end else begin
			if (reg_wr && (reg_addr == IRQ_STATUS_OFF)) begin
				irq_status <= (irq_status & ~reg_wdata[IRQ_W-1:0]) | irq_events;
			end else begin
				irq_status <= irq_status | irq_events;
			end
			if (reg_wr && (reg_addr == IRQ_MASK_OFF)) begin
				irq_mask <= reg_wdata[IRQ_W-1:0];
			end
		end
	end

	assign irq = |(irq_status & irq_mask);

	// Strobe bits always read zero; other-mode bits read zero
	always_comb begin
		ctrl_view = CTRL_RESET;
		ctrl_view[CTL_SLEEP] = sleep_enable && slave_mode;
		ctrl_view[CTL_DIR] = frame_direction;
		ctrl_view[CTL_DACK] = slave_data_ack && slave_mode;
		ctrl_view[CTL_WAKE] = wake_request;
		ctrl_view[CTL_START] = frame_start_request && master_mode;
		status_view = {bus_active, bus_idle_timeout_flag && slave_mode, abort_flag && slave_mode,
			slave_data_request && slave_mode, irq_pending_flag, error_flag,
			wake_request || wakeup_seen, done_flag};
	end

	always_comb begin
		next_rdata = '0;
		if (byte_sel) begin
			next_rdata = frame_byte[byte_idx];
		end else if (reg_addr == LINK_CONTROL_OFF) begin
			next_rdata = ctrl_view;
		end else if (reg_addr == LINK_STATUS_OFF) begin
			next_rdata = status_view;
		end else if (reg_addr == IRQ_STATUS_OFF) begin
			next_rdata = DATA_W'(irq_status);
		end else if (reg_addr == IRQ_MASK_OFF) begin
			next_rdata = DATA_W'(irq_mask);
		end
	end

	// Data stand only in the cycle after the read
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end else begin
			reg_rdata <= '0;
		end
	end

	start_clear_a: assert property (@(posedge core_clk) disable iff (rst)
		(frame_done && !frame_start) |=> !frame_start_request)
		else $error("start request not cleared at done");
	start_master_a: assert property (@(posedge core_clk) disable iff (rst)
		(ctl_wr && reg_wdata[CTL_START] && slave_mode) |-> !frame_start)
		else $error("start pulse in slave mode");
	halt_hold_a: assert property (@(posedge core_clk) disable iff (rst)
		(halt_wr || (comm_halted && !break_detected)) |=> comm_halted)
		else $error("halt dropped without break");
	ack_self_clear_a: assert property (@(posedge core_clk) disable iff (rst)
		slave_data_ack |=> !slave_data_ack)
		else $error("data ack not self cleared");
	irq_flag_hold_a: assert property (@(posedge core_clk) disable iff (rst)
		(irq_pending_flag && !irq_clear_strobe) |=> irq_pending_flag)
		else $error("pending flag lost without clear");
	irq_flag_clear_a: assert property (@(posedge core_clk) disable iff (rst)
		(irq_clear_strobe && !(|irq_events)) |=> !irq_pending_flag)
		else $error("pending flag not cleared");
	err_clear_a: assert property (@(posedge core_clk) disable iff (rst)
		(err_clear_strobe && !frame_error) |=> !error_flag)
		else $error("error flag not cleared");
	done_cycle_a: assert property (@(posedge core_clk) disable iff (rst)
		(frame_start && !frame_done) |=> !done_flag)
		else $error("done flag not cleared at start");
	mode_read_a: assert property (@(posedge core_clk) disable iff (rst)
		(reg_rd && reg_addr == LINK_CONTROL_OFF && master_mode) |=> !reg_rdata[CTL_SLEEP])
		else $error("slave bit readable in master mode");
	strobe_read_a: assert property (@(posedge core_clk) disable iff (rst)
		(reg_rd && reg_addr == LINK_CONTROL_OFF) |=> (reg_rdata[CTL_HALT:CTL_HALT] == 1'b0
		&& reg_rdata[CTL_ICLR] == 1'b0 && reg_rdata[CTL_ECLR] == 1'b0))
		else $error("strobe bit read as one");
	sleep_enter_a: assert property (@(posedge core_clk) disable iff (rst)
		(slave_mode && sleep_enable && idle_timeout) |=> sleep_mode)
		else $error("sleep not entered on timeout");
	wake_release_a: assert property (@(posedge core_clk) disable iff (rst)
		(wake_request && wakeup_sent && !(ctl_wr && reg_wdata[CTL_WAKE])) |=> !wake_request)
		else $error("wake request not released");
	byte_write_a: assert property (@(posedge core_clk) disable iff (rst)
		(reg_wr && reg_addr == FRAME_DATA_BYTE_3_OFF) |=> frame_bytes[DATA_W-1:0] == $past(reg_wdata))
		else $error("data byte not stored");

	start_seen_c: cover property (@(posedge core_clk) disable iff (rst) frame_start ##[1:50] frame_done);
	slave_ack_c: cover property (@(posedge core_clk) disable iff (rst)
		slave_data_request ##1 slave_data_ack);
	sleep_wake_c: cover property (@(posedge core_clk) disable iff (rst)
		sleep_mode ##[1:50] !sleep_mode);
	irq_out_c: cover property (@(posedge core_clk) disable iff (rst) irq ##[1:20] !irq);
endmodule
`default_nettype wire

//--- verilog/link_ctrl_pkg.sv
// Purpose: Shared constants for the LIN control register and frame data buffer.
// Assumes: 8-bit register port with direct byte offsets.
// Notes:   Interrupt status and mask registers sit above the control window.
`default_nettype none
package link_ctrl_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int NUM_BYTES = 4;
	localparam int BIDX_W = 2;
	localparam int IRQ_W = 6;

	// Register offsets
	localparam logic [ADDR_W-1:0] FRAME_DATA_BYTE_3_OFF = 8'h02;
	localparam logic [ADDR_W-1:0] FRAME_DATA_BYTE_6_OFF = 8'h05;
	localparam logic [ADDR_W-1:0] LINK_CONTROL_OFF      = 8'h08;
	localparam logic [ADDR_W-1:0] LINK_STATUS_OFF       = 8'h09;
	localparam logic [ADDR_W-1:0] IRQ_STATUS_OFF        = 8'h10;
	localparam logic [ADDR_W-1:0] IRQ_MASK_OFF          = 8'h11;

	// Control field positions
	localparam int CTL_HALT  = 7;
	localparam int CTL_SLEEP = 6;
	localparam int CTL_DIR   = 5;
	localparam int CTL_DACK  = 4;
	localparam int CTL_ICLR  = 3;
	localparam int CTL_ECLR  = 2;
	localparam int CTL_WAKE  = 1;
	localparam int CTL_START = 0;

	// Status field positions
	localparam int ST_ACTIVE = 7;
	localparam int ST_IDLE   = 6;
	localparam int ST_ABORT  = 5;
	localparam int ST_DREQ   = 4;
	localparam int ST_IRQ    = 3;
	localparam int ST_ERROR  = 2;
	localparam int ST_WAKEUP = 1;
	localparam int ST_DONE   = 0;

	// Interrupt status positions
	localparam int IRQ_DONE  = 0;
	localparam int IRQ_ERR   = 1;
	localparam int IRQ_DREQ  = 2;
	localparam int IRQ_WAKE  = 3;
	localparam int IRQ_IDLE  = 4;
	localparam int IRQ_ABORT = 5;

	// Reset values
	localparam logic [DATA_W-1:0] BYTE_RESET = 8'h00;
	localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
	localparam logic [IRQ_W-1:0]  IRQ_RESET  = 6'h00;
endpackage
`default_nettype wire

//--- bench/lin_engine_model.sv
// Purpose: Frame engine stand-in that answers start and wakeup requests.
// Assumes: DELAY+1 cycles of bus time per frame and per wakeup.
// Notes:   Ends a frame in error instead of completion while fail is high.
`timescale 1ns/1ps
`default_nettype none
module lin_engine_model #(
	parameter int DELAY = 6
) (
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic frame_start,
	input  wire logic wake_request,
	input  wire logic fail,
	output logic      frame_done,
	output logic      frame_error,
	output logic      wakeup_sent,
	output logic      bus_active
);
	int cnt;
	int wcnt;

	// Frame occupies the bus for a while, so status can be read mid-frame
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cnt         <= 0;
			bus_active  <= 1'b0;
			frame_done  <= 1'b0;
			frame_error <= 1'b0;
		end else begin
			frame_done  <= 1'b0;
			frame_error <= 1'b0;
			if (frame_start) begin
				bus_active <= 1'b1;
				cnt        <= DELAY;
			end else if (bus_active && cnt == 0) begin
				bus_active  <= 1'b0;
				frame_done  <= !fail;
				frame_error <= fail;
			end else if (bus_active) begin
				cnt <= cnt - 1;
			end
		end
	end

	// Wakeup goes out late, never in the cycle of the request
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wcnt        <= 0;
			wakeup_sent <= 1'b0;
		end else begin
			wakeup_sent <= wake_request && !wakeup_sent && wcnt == DELAY;
			wcnt        <= (wake_request && wcnt < DELAY) ? wcnt + 1 : 0;
		end
	end
endmodule
`default_nettype wire

//--- bench/lin_control_data_buffer_tb.sv
// Purpose: Register-level tests of the LIN control and data buffer block.
// Assumes: One-cycle strobes; read data in the cycle after the strobe.
// Notes:   ev bits: aborted, break, sleep frame, idle, wakeup rx, data id, rx we.
`timescale 1ns/1ps
`default_nettype none
module lin_control_data_buffer_tb;
	import link_ctrl_pkg::*;
	logic              core_clk, rst, reg_wr, reg_rd, master_mode, fail;
	logic [7:0]        reg_addr, reg_wdata, reg_rdata, rx_byte, d;
	logic [1:0]        rx_byte_idx;
	logic [6:0]        ev;
	logic [31:0]       frame_bytes;
	logic              bus_active, frame_done, frame_error, wakeup_sent, frame_start;
	logic              frame_direction, slave_data_ack, comm_halted, sleep_mode;
	logic              wake_request, err_clear_strobe, irq;
	int                fail_count, cmp_count, starts, dacks, eclrs;

	lin_control_data_buffer i_lin_control_data_buffer (
		.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .master_mode(master_mode),
		.bus_active(bus_active), .frame_done(frame_done), .frame_error(frame_error),
		.frame_aborted(ev[0]), .break_detected(ev[1]), .sleep_frame_rx(ev[2]),
		.idle_timeout(ev[3]), .wakeup_rx(ev[4]), .wakeup_sent(wakeup_sent),
		.data_id_rx(ev[5]), .rx_byte_we(ev[6]), .rx_byte_idx(rx_byte_idx),
		.rx_byte(rx_byte), .frame_bytes(frame_bytes), .frame_start(frame_start),
		.frame_direction(frame_direction), .slave_data_ack(slave_data_ack),
		.comm_halted(comm_halted), .sleep_mode(sleep_mode), .wake_request(wake_request),
		.err_clear_strobe(err_clear_strobe), .irq(irq));

	lin_engine_model i_lin_engine_model (
		.core_clk(core_clk), .rst(rst), .frame_start(frame_start),
		.wake_request(wake_request), .fail(fail), .frame_done(frame_done),
		.frame_error(frame_error), .wakeup_sent(wakeup_sent), .bus_active(bus_active));

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	// Pulses are counted at the edge that takes them
	always @(posedge core_clk) begin
		if (frame_start === 1'b1) starts++;
		if (slave_data_ack === 1'b1) dacks++;
		if (err_clear_strobe === 1'b1) eclrs++;
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] v;
		rd(a, v);
		chk(v, e);
	endtask

	task automatic pulse(input int b);
		@(posedge core_clk);
		ev[b] <= 1'b1;
		@(posedge core_clk);
		ev <= '0;
		#1;
	endtask

	// Bounded wait; running out of cycles counts as a mismatch
	task automatic wait_low(input int s);
		int n;
		n = 0;
		while ((s ? wake_request : bus_active) !== 1'b0 && n < 100) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		chk(32'(n < 100), 32'h1);
	endtask

	initial begin
		#(3000 * 100);
		fail_count++;
		end_of_test();
	end

	initial begin
		{rst, reg_wr, reg_rd, master_mode, fail} = 5'b10000;
		{reg_addr, reg_wdata, rx_byte, rx_byte_idx, ev} = '0;
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		for (int i = 2; i < 10; i++) rdc(8'(i), 8'h00);
		for (int i = 0; i < 4; i++) wr(8'(2 + i), 8'(8'h11 * (i + 1)));
		wr(8'h06, 8'hFF);
		for (int i = 0; i < 4; i++) rdc(8'(2 + i), 8'(8'h11 * (i + 1)));
		rdc(8'h06, 8'h00);
		chk(frame_bytes, 32'h4433_2211);
		rx_byte_idx <= 2'd2;
		rx_byte     <= 8'hC3;
		pulse(6);
		rdc(8'h04, 8'hC3);
		master_mode <= 1'b1;
		wr(8'h08, 8'h21);
		chk(frame_direction, 1'b1);
		chk(starts, 1);
		wait_low(0);
		rdc(8'h08, 8'h20);
		rdc(8'h09, 8'h09);
		wr(8'h11, 8'h01);
		chk(irq, 1'b1);
		wr(8'h10, 8'h01);
		chk(irq, 1'b0);
		rdc(8'h09, 8'h09);
		wr(8'h08, 8'h28);
		rdc(8'h09, 8'h01);
		rdc(8'h08, 8'h20);
		fail <= 1'b1;
		wr(8'h08, 8'h21);
		rdc(8'h09, 8'h80);
		wait_low(0);
		rdc(8'h09, 8'h0C);
		rdc(8'h08, 8'h20);
		wr(8'h08, 8'h24);
		chk(eclrs, 1);
		rdc(8'h09, 8'h08);
		wr(8'h08, 8'hD0);
		rdc(8'h08, 8'h00);
		chk(comm_halted, 1'b0);
		master_mode <= 1'b0;
		wr(8'h08, 8'h01);
		chk(starts, 2);
		chk(dacks, 0);
		wr(8'h08, 8'h80);
		chk(comm_halted, 1'b1);
		rdc(8'h08, 8'h00);
		pulse(1);
		chk(comm_halted, 1'b0);
		pulse(5);
		rd(8'h09, d);
		chk(d & 8'h10, 8'h10);
		wr(8'h08, 8'h10);
		rdc(8'h08, 8'h00);
		chk(dacks, 1);
		rdc(8'h09, 8'h08);
		wr(8'h08, 8'h40);
		pulse(2);
		chk(sleep_mode, 1'b1);
		pulse(4);
		chk(sleep_mode, 1'b1);
		wr(8'h08, 8'h00);
		pulse(4);
		chk(sleep_mode, 1'b0);
		wr(8'h08, 8'h40);
		pulse(3);
		chk(sleep_mode, 1'b1);
		wr(8'h08, 8'h42);
		chk(wake_request, 1'b1);
		wait_low(1);
		rdc(8'h08, 8'h40);
		chk(sleep_mode, 1'b0);
		end_of_test();
	end
endmodule
`default_nettype wire
